// ===== rtcfc_pkg.sv
`default_nettype none
package rtcfc_pkg;
    // register indexes behind the index/data port
    localparam logic [7:0] IDX_SEC = 8'h00;
    localparam logic [7:0] IDX_MIN = 8'h02;
    localparam logic [7:0] IDX_HR = 8'h04;
    localparam logic [7:0] IDX_ALM_HR = 8'h05;
    localparam logic [7:0] IDX_DOW = 8'h06;
    localparam logic [7:0] IDX_DATE = 8'h07;
    localparam logic [7:0] IDX_MONTH = 8'h08;
    localparam logic [7:0] IDX_YEAR = 8'h09;
    localparam logic [7:0] IDX_CTL = 8'h0B;
    localparam logic [7:0] IDX_STAT = 8'h0C;
    localparam logic [7:0] TIME_REGS = 8'h0A;

    // rtc_irq_format_control fields
    localparam int CTL_SET_BIT = 7;
    localparam int CTL_PER_EN_BIT = 6;
    localparam int CTL_ALM_EN_BIT = 5;
    localparam int CTL_UPD_EN_BIT = 4;
    localparam int CTL_BIN_BIT = 2;
    localparam int CTL_24H_BIT = 1;
    localparam int CTL_DST_BIT = 0;
    localparam logic CTL_RSV_VAL = 1'b0;
    // rtc_irq_status fields, and the hour register pm bit
    localparam int STAT_IRQ_BIT = 7;
    localparam int STAT_UPD_BIT = 4;
    localparam int HOUR_PM_BIT = 7;

    // calendar limits, binary
    localparam logic [7:0] SEC_MAX = 8'h3B;
    localparam logic [7:0] MIN_MAX = 8'h3B;
    localparam logic [7:0] DOW_MAX = 8'h07;
    localparam logic [7:0] MONTH_MAX = 8'h0C;
    localparam logic [7:0] YEAR_MAX = 8'h63;
    localparam logic [7:0] FIRST_VAL = 8'h01;
    localparam logic [7:0] ZERO_VAL = 8'h00;
    localparam logic [7:0] HOURS_HALF = 8'h0C;
    localparam logic [7:0] HOURS_LAST = 8'h17;
    localparam logic [7:0] DAYS_31 = 8'h1F;
    localparam logic [7:0] DAYS_30 = 8'h1E;
    localparam logic [7:0] DAYS_29 = 8'h1D;
    localparam logic [7:0] DAYS_28 = 8'h1C;
    localparam logic [7:0] MONTH_FEB = 8'h02;
    localparam logic [7:0] MONTH_APR = 8'h04;
    localparam logic [7:0] MONTH_JUN = 8'h06;
    localparam logic [7:0] MONTH_SEP = 8'h09;
    localparam logic [7:0] MONTH_OCT = 8'h0A;
    localparam logic [7:0] MONTH_NOV = 8'h0B;
    localparam logic [7:0] SUNDAY = 8'h01;
    localparam logic [7:0] FIRST_WEEK_LAST = 8'h07;
    localparam logic [7:0] LAST_WEEK_FIRST = 8'h19;
    localparam logic [7:0] DST_HOUR = 8'h01;
    localparam logic [7:0] SPRING_HOUR = 8'h03;

    // one update per second
    localparam int UPDATE_PERIOD_NS = 1000000000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int UPDATE_CYCLES = UPDATE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 26;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] index;
        logic [7:0] wdata;
    } rtcfc_req_s;

    // cleared by the rtc-only reset
    typedef struct packed {
        logic upd_en;
        logic per_en;
        logic alm_en;
        logic upd_flag;
        logic irq_flag;
        logic [7:0] rdata;
        logic [TICK_W-1:0] tick_cnt;
    } rtcfc_core_s;

    // survives the rtc-only reset, cleared only at power-on
    typedef struct packed {
        logic set;
        logic mode_bin;
        logic mode_24h;
        logic dst_en;
        logic fall_done;
        logic [9:0][7:0] tm;
    } rtcfc_kept_s;

    localparam rtcfc_core_s CORE_RST = '0;
    localparam rtcfc_kept_s KEPT_POR = '0;

    function automatic logic [7:0] rtcfc_to_bin(input logic [7:0] v,
                                                input logic bin);
        return bin ? v : ({4'h0, v[7:4]} * 8'h0A) + {4'h0, v[3:0]};
    endfunction

    function automatic logic [7:0] rtcfc_to_code(input logic [7:0] v,
                                                 input logic bin);
        return bin ? v : {4'(v / 8'h0A), 4'(v % 8'h0A)};
    endfunction
endpackage
`default_nettype wire

// ===== rtcfc_step.sv
`timescale 1ns/10ps
`default_nettype none
module rtcfc_step (
    input wire logic [7:0] i_val, // field in current encoding
    input wire logic i_bin, // 1 binary, 0 bcd
    input wire logic [7:0] i_lo, // wrap value, binary
    input wire logic [7:0] i_hi, // last value, binary
    input wire logic i_inc, // advance this field
    output logic [7:0] o_val, // next field value
    output logic o_wrap // carry to next field
);
    import rtcfc_pkg::*;
    logic [7:0] cur;

    always_comb begin
        cur = rtcfc_to_bin(i_val, i_bin);
        o_val = i_val;
        o_wrap = 1'b0;
        if (i_inc) begin
            // out-of-range values also wrap, so bad writes recover
            if (cur >= i_hi) begin
                o_wrap = 1'b1;
                o_val = rtcfc_to_code(i_lo, i_bin);
            end else begin
                o_val = rtcfc_to_code(cur + 8'h01, i_bin);
            end
        end
    end
endmodule
`default_nettype wire

// ===== rtcfc_core.sv
// Function
// RULE_01: enabled update flag rise latches interrupt flag
// RULE_02: enabling with flag already set raises interrupt
// RULE_03: enable cleared by reset or inhibit write
// RULE_04: software writes zero to reserved bit
// RULE_05: encoding select picks bcd or binary
// RULE_06: format and summer bits survive rtc reset
// RULE_07: software rewrites time registers after encoding change
// RULE_08: software inhibits updates while changing format bits
// RULE_09: hour select picks 12h with pm or 24h
// RULE_10: software rewrites hour registers after format change
// RULE_11: april first sunday skips 2am hour
// RULE_12: october last sunday repeats 1am hour; code repeats it only if the first update at 1am is at 01:59:59
// RULE_13: software sets interrupt routing before enabling
// RULE_14: inhibit stops and aborts once-per-second updates
// RULE_15: update flag set after every update
`timescale 1ns/10ps
`default_nettype none
module rtcfc_core #(
    parameter int TICK_CYCLES = rtcfc_pkg::UPDATE_CYCLES // cycles a second
) (
    input wire logic i_core_clk, // 40 MHz
    input wire logic i_reset_n, // rtc-only reset, async
    input wire logic i_por_n, // power-on reset, async
    input wire rtcfc_pkg::rtcfc_req_s i_reg_req, // index/data access
    output logic [7:0] o_reg_rdata, // read data, next cycle
    output logic o_irq_req // interrupt request flag
);
    import rtcfc_pkg::*;

    localparam int NUNIT = 6;
    localparam int UNIT_IDX [NUNIT] = '{int'(IDX_SEC), int'(IDX_MIN),
        int'(IDX_DOW), int'(IDX_DATE), int'(IDX_MONTH), int'(IDX_YEAR)};
    localparam logic [7:0] UNIT_LO [NUNIT] = '{ZERO_VAL, ZERO_VAL,
        FIRST_VAL, FIRST_VAL, FIRST_VAL, ZERO_VAL};

    rtcfc_core_s st_q, st_d;
    rtcfc_kept_s kp_q, kp_d;

    logic [7:0] wd;
    logic ctl_wr, stat_rd, update, en_write;
    logic [7:0] month_b, date_b, dow_b, year_b, days_max;
    logic [7:0] hr_raw, h12, hr_bin, hr_next, h12n, hr_next_raw, h12c;
    logic hr_inc, day_inc, spring, fall;
    logic [NUNIT-1:0] unit_inc, unit_wrap;
    logic [7:0] unit_hi [NUNIT];
    logic [7:0] unit_next [NUNIT];

    assign wd = i_reg_req.wdata;
    assign ctl_wr = i_reg_req.wr && i_reg_req.index == IDX_CTL;
    assign stat_rd = i_reg_req.rd && i_reg_req.index == IDX_STAT;
    assign en_write = ctl_wr && wd[CTL_UPD_EN_BIT] && !wd[CTL_SET_BIT];
    // a set written in the tick cycle aborts that update
    assign update = st_q.tick_cnt == TICK_W'(TICK_CYCLES - 1)
        && !kp_q.set && !(ctl_wr && wd[CTL_SET_BIT]); // see RULE_14

    assign month_b = rtcfc_to_bin(kp_q.tm[IDX_MONTH], kp_q.mode_bin);
    assign date_b = rtcfc_to_bin(kp_q.tm[IDX_DATE], kp_q.mode_bin);
    assign dow_b = rtcfc_to_bin(kp_q.tm[IDX_DOW], kp_q.mode_bin);
    assign year_b = rtcfc_to_bin(kp_q.tm[IDX_YEAR], kp_q.mode_bin);

    always_comb begin
        unique case (month_b)
            MONTH_FEB: days_max = (year_b[1:0] == 2'h0) ? DAYS_29 : DAYS_28;
            MONTH_APR, MONTH_JUN, MONTH_SEP, MONTH_NOV: days_max = DAYS_30;
            default: days_max = DAYS_31;
        endcase
    end

    assign unit_hi[0] = SEC_MAX;
    assign unit_hi[1] = MIN_MAX;
    assign unit_hi[2] = DOW_MAX;
    assign unit_hi[3] = days_max;
    assign unit_hi[4] = MONTH_MAX;
    assign unit_hi[5] = YEAR_MAX;

    assign unit_inc[0] = update;
    assign unit_inc[1] = unit_wrap[0];
    assign unit_inc[2] = day_inc;
    assign unit_inc[3] = day_inc;
    assign unit_inc[4] = unit_wrap[3];
    assign unit_inc[5] = unit_wrap[4];

    for (genvar u = 0; u < NUNIT; u++) begin : g_unit
        rtcfc_step u_step (
            .i_val (kp_q.tm[UNIT_IDX[u]]),
            .i_bin (kp_q.mode_bin),
            .i_lo (UNIT_LO[u]),
            .i_hi (unit_hi[u]),
            .i_inc (unit_inc[u]),
            .o_val (unit_next[u]),
            .o_wrap (unit_wrap[u])
        ); // see RULE_05
    end

    // hours run on a 0..23 scale internally, recoded per format
    always_comb begin
        hr_raw = kp_q.tm[IDX_HR];
        h12 = rtcfc_to_bin({1'b0, hr_raw[6:0]}, kp_q.mode_bin);
        if (kp_q.mode_24h) begin
            hr_bin = rtcfc_to_bin(hr_raw, kp_q.mode_bin);
        end else begin
            hr_bin = ((h12 == HOURS_HALF) ? ZERO_VAL : h12)
                + (hr_raw[HOUR_PM_BIT] ? HOURS_HALF : ZERO_VAL); // see RULE_09
        end
        hr_inc = unit_wrap[1];
        spring = kp_q.dst_en && month_b == MONTH_APR && dow_b == SUNDAY
            && date_b <= FIRST_WEEK_LAST && hr_bin == DST_HOUR; // see RULE_11
        // fall_done stops the repeated hour from repeating forever
        fall = kp_q.dst_en && month_b == MONTH_OCT && dow_b == SUNDAY
            && date_b >= LAST_WEEK_FIRST && hr_bin == DST_HOUR
            && !kp_q.fall_done; // see RULE_12
        day_inc = hr_inc && !spring && !fall && hr_bin >= HOURS_LAST;
        if (spring) begin
            hr_next = SPRING_HOUR;
        end else if (fall) begin
            hr_next = DST_HOUR;
        end else if (hr_bin >= HOURS_LAST) begin
            hr_next = ZERO_VAL;
        end else begin
            hr_next = hr_bin + 8'h01;
        end
        h12n = (hr_next >= HOURS_HALF) ? hr_next - HOURS_HALF : hr_next;
        if (h12n == ZERO_VAL) begin
            h12n = HOURS_HALF;
        end
        h12c = rtcfc_to_code(h12n, kp_q.mode_bin);
        if (kp_q.mode_24h) begin
            hr_next_raw = rtcfc_to_code(hr_next, kp_q.mode_bin);
        end else begin
            hr_next_raw = {hr_next >= HOURS_HALF, h12c[6:0]}; // see RULE_09
        end
    end

    always_comb begin
        st_d = st_q;
        kp_d = kp_q;
        st_d.tick_cnt = (st_q.tick_cnt == TICK_W'(TICK_CYCLES - 1))
            ? '0 : st_q.tick_cnt + TICK_W'(1);

        if (i_reg_req.rd) begin
            st_d.rdata = 8'h00;
            if (i_reg_req.index < TIME_REGS) begin
                st_d.rdata = kp_q.tm[i_reg_req.index[3:0]];
            end else if (i_reg_req.index == IDX_CTL) begin
                st_d.rdata = {kp_q.set, st_q.per_en, st_q.alm_en,
                    st_q.upd_en, CTL_RSV_VAL, kp_q.mode_bin,
                    kp_q.mode_24h, kp_q.dst_en};
            end else if (stat_rd) begin
                st_d.rdata = 8'h00;
                st_d.rdata[STAT_IRQ_BIT] = st_q.irq_flag;
                st_d.rdata[STAT_UPD_BIT] = st_q.upd_flag;
            end
        end
        // clears first so that a same-cycle set wins
        if (stat_rd) begin
            st_d.irq_flag = 1'b0;
            st_d.upd_flag = 1'b0;
        end

        if (update) begin
            for (int u = 0; u < NUNIT; u++) begin
                kp_d.tm[UNIT_IDX[u]] = unit_next[u];
            end
            if (hr_inc) begin
                kp_d.tm[IDX_HR] = hr_next_raw;
            end
            if (fall) begin
                kp_d.fall_done = 1'b1;
            end else if (day_inc) begin
                kp_d.fall_done = 1'b0;
            end
            st_d.upd_flag = 1'b1; // see RULE_15
            if (st_q.upd_en && !st_q.upd_flag) begin
                st_d.irq_flag = 1'b1; // see RULE_01
            end
        end

        // software writes win over the update of the same byte
        if (i_reg_req.wr && i_reg_req.index < TIME_REGS) begin
            kp_d.tm[i_reg_req.index[3:0]] = wd;
        end
        if (ctl_wr) begin
            kp_d.set = wd[CTL_SET_BIT];
            kp_d.mode_bin = wd[CTL_BIN_BIT];
            kp_d.mode_24h = wd[CTL_24H_BIT];
            kp_d.dst_en = wd[CTL_DST_BIT];
            st_d.per_en = wd[CTL_PER_EN_BIT];
            st_d.alm_en = wd[CTL_ALM_EN_BIT];
            st_d.upd_en = en_write; // see RULE_03
            if (en_write && st_q.upd_flag) begin
                st_d.irq_flag = 1'b1; // see RULE_02
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q <= CORE_RST; // see RULE_03
        end else begin
            st_q <= st_d;
        end
    end

    // format bits live apart so the rtc-only reset leaves them alone
    always_ff @(posedge i_core_clk or negedge i_por_n) begin
        if (!i_por_n) begin
            kp_q <= KEPT_POR;
        end else begin
            kp_q <= kp_d; // see RULE_06
        end
    end

    assign o_reg_rdata = st_q.rdata;
    assign o_irq_req = st_q.irq_flag;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_reset_n || !i_por_n);

    a_upd_irq_latch: assert property ( // see RULE_01
        update && st_q.upd_en && !st_q.upd_flag |=> st_q.irq_flag
    ) else $error("update event with enable did not raise irq");

    a_upd_irq_quiet: assert property ( // see RULE_01
        !st_q.upd_en && !st_q.irq_flag && !en_write |=> !st_q.irq_flag
    ) else $error("irq raised while update irq disabled");

    a_en_write_irq: assert property ( // see RULE_02
        en_write && st_q.upd_flag |=> st_q.irq_flag && st_q.upd_en
    ) else $error("enable over pending flag did not raise irq");

    a_set_clears_en: assert property ( // see RULE_03
        ctl_wr && wd[CTL_SET_BIT] |=> !st_q.upd_en && kp_q.set
    ) else $error("inhibit write left update enable set");

    a_en_sw_only: assert property ( // see RULE_03
        !ctl_wr |=> $stable(st_q.upd_en)
    ) else $error("update enable changed without a write");

    a_cfg_kept: assert property (@(posedge i_core_clk) // see RULE_06
        disable iff (!i_por_n)
        !ctl_wr |=> $stable({kp_q.mode_bin, kp_q.mode_24h, kp_q.dst_en})
    ) else $error("format bits changed without a write");

    a_bcd_carry: assert property ( // see RULE_05
        update && !kp_q.mode_bin && kp_q.tm[IDX_SEC] == 8'h09
            && !(i_reg_req.wr && i_reg_req.index == IDX_SEC)
        |=> kp_q.tm[IDX_SEC] == 8'h10
    ) else $error("bcd seconds did not carry 09 to 10");

    a_noon_12h: assert property ( // see RULE_09
        hr_inc && !kp_q.mode_24h && !kp_q.mode_bin && hr_raw == 8'h11
            && !i_reg_req.wr
        |=> kp_q.tm[IDX_HR] == 8'h92
    ) else $error("11 am did not advance to 12 pm");

    a_dst_spring: assert property ( // see RULE_11
        hr_inc && spring && !i_reg_req.wr |=> hr_bin == SPRING_HOUR
    ) else $error("spring change did not jump to 3 am");

    a_dst_fall: assert property ( // see RULE_12
        hr_inc && fall && !i_reg_req.wr
        |=> hr_bin == DST_HOUR && kp_q.fall_done
    ) else $error("fall change did not repeat 1 am");

    a_set_freezes: assert property ( // see RULE_14
        kp_q.set && !i_reg_req.wr |=> $stable(kp_q.tm)
    ) else $error("time moved while updates inhibited");

    a_upd_flag_set: assert property ( // see RULE_15
        update |=> st_q.upd_flag
    ) else $error("update flag not set after update");
endmodule
`default_nettype wire

// ===== tb_rtcfc_core.sv
`timescale 1ns/10ps
`default_nettype none
module tb_rtcfc_core;
    import rtcfc_pkg::*;
    // short second keeps each update window to a few cycles
    localparam int TICKS = 16;
    logic i_core_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_por_n = 1'b0;
    rtcfc_req_s i_reg_req = '0;
    logic [7:0] o_reg_rdata;
    logic o_irq_req;
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [7:0] rv;

    rtcfc_core #(.TICK_CYCLES(TICKS)) uut (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .i_por_n(i_por_n),
        .i_reg_req(i_reg_req),
        .o_reg_rdata(o_reg_rdata),
        .o_irq_req(o_irq_req)
    );

    always #12.5 i_core_clk = ~i_core_clk;

    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count = err_count + 1;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic cyc();
        @(posedge i_core_clk);
        #2;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // idle cycle after each strobe so no signal is driven twice at once
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        i_reg_req = '{wr: 1'b1, rd: 1'b0, index: idx, wdata: d};
        cyc();
        i_reg_req = '0;
        cyc();
    endtask

    task automatic rd(input logic [7:0] idx);
        i_reg_req = '{wr: 1'b0, rd: 1'b1, index: idx, wdata: 8'h00};
        cyc();
        rv = o_reg_rdata;
        i_reg_req = '0;
        cyc();
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        rd(idx);
        chk(rv, exp);
    endtask

    // exactly TICKS edges with updates allowed, so one update happens
    task automatic run_one(input logic [7:0] mode);
        wr(IDX_CTL, mode);
        repeat (TICKS - 1) cyc();
        wr(IDX_CTL, mode | 8'h80);
    endtask

    task automatic rtc_pulse();
        i_reset_n = 1'b0;
        cyc();
        cyc();
        i_reset_n = 1'b1;
        cyc();
    endtask

    task automatic set_time(input logic [7:0] mode, input logic [7:0] mo,
                            input logic [7:0] dt, input logic [7:0] dw,
                            input logic [7:0] hr, input logic [7:0] mi,
                            input logic [7:0] se);
        wr(IDX_CTL, mode | 8'h80);
        wr(IDX_MONTH, mo);
        wr(IDX_DATE, dt);
        wr(IDX_DOW, dw);
        wr(IDX_YEAR, 8'h05);
        wr(IDX_HR, hr);
        wr(IDX_ALM_HR, hr);
        wr(IDX_MIN, mi);
        wr(IDX_SEC, se);
    endtask

    task automatic time_case(input logic [7:0] mode, input logic [7:0] mo,
                             input logic [7:0] dt, input logic [7:0] dw,
                             input logic [7:0] hr, input logic [7:0] mi,
                             input logic [7:0] se, input logic [7:0] eh,
                             input logic [7:0] em, input logic [7:0] es);
        set_time(mode, mo, dt, dw, hr, mi, se);
        run_one(mode);
        rd_chk(IDX_HR, eh);
        rd_chk(IDX_MIN, em);
        rd_chk(IDX_SEC, es);
    endtask

    task automatic t_reset();
        rd_chk(IDX_CTL, 8'h00);
        chk({7'h00, o_irq_req}, 8'h00);
        wr(IDX_CTL, 8'h80);
        rd(IDX_STAT);
        rd_chk(IDX_STAT, 8'h00);
        wr(8'h0A, 8'h55);
        rd_chk(8'h0A, 8'h00);
    endtask

    task automatic t_irq();
        run_one(8'h00);
        chk({7'h00, o_irq_req}, 8'h00);
        rd_chk(IDX_STAT, 8'h10);
        // irq routing sits outside this block, set before any enable
        run_one(8'h10);
        chk({7'h00, o_irq_req}, 8'h01);
        rd_chk(IDX_STAT, 8'h90);
        chk({7'h00, o_irq_req}, 8'h00);
        run_one(8'h00);
        chk({7'h00, o_irq_req}, 8'h00);
        wr(IDX_CTL, 8'h10);
        chk({7'h00, o_irq_req}, 8'h01);
        wr(IDX_CTL, 8'h80);
        rd(IDX_STAT);
    endtask

    task automatic t_ctl_bits();
        wr(IDX_CTL, 8'h97);
        rd_chk(IDX_CTL, 8'h87);
        wr(IDX_CTL, 8'h17);
        rd_chk(IDX_CTL, 8'h17);
        rtc_pulse();
        rd_chk(IDX_CTL, 8'h07);
        chk({7'h00, o_irq_req}, 8'h00);
        wr(IDX_CTL, 8'h86);
        rtc_pulse();
        rd_chk(IDX_CTL, 8'h86);
    endtask

    task automatic t_inhibit();
        set_time(8'h02, 8'h05, 8'h10, 8'h03, 8'h10, 8'h20, 8'h09);
        repeat (3 * TICKS) cyc();
        rd_chk(IDX_SEC, 8'h09);
        rd_chk(IDX_MIN, 8'h20);
        run_one(8'h02);
        rd_chk(IDX_SEC, 8'h10);
    endtask

    task automatic t_time();
        time_case(8'h02, 8'h05, 8'h10, 8'h03, 8'h23, 8'h59, 8'h59,
                  8'h00, 8'h00, 8'h00);
        time_case(8'h06, 8'h05, 8'h0A, 8'h03, 8'h17, 8'h3B, 8'h3B,
                  8'h00, 8'h00, 8'h00);
        time_case(8'h00, 8'h05, 8'h10, 8'h03, 8'h11, 8'h59, 8'h59,
                  8'h92, 8'h00, 8'h00);
        time_case(8'h00, 8'h05, 8'h10, 8'h03, 8'h92, 8'h59, 8'h59,
                  8'h81, 8'h00, 8'h00);
        time_case(8'h04, 8'h05, 8'h0A, 8'h03, 8'h0B, 8'h3B, 8'h3B,
                  8'h8C, 8'h00, 8'h00);
        time_case(8'h01, 8'h04, 8'h03, 8'h01, 8'h01, 8'h59, 8'h59,
                  8'h03, 8'h00, 8'h00);
        time_case(8'h00, 8'h04, 8'h03, 8'h01, 8'h01, 8'h59, 8'h59,
                  8'h02, 8'h00, 8'h00);
        time_case(8'h01, 8'h10, 8'h28, 8'h01, 8'h01, 8'h59, 8'h59,
                  8'h01, 8'h00, 8'h00);
    endtask

    initial begin
        repeat (16) @(posedge i_core_clk);
        #2;
        i_reset_n = 1'b1;
        i_por_n = 1'b1;
        t_reset();
        t_irq();
        t_ctl_bits();
        t_inhibit();
        t_time();
        complete_run();
    end
endmodule
`default_nettype wire
